/* File: core/pci_bridge_io_address_decoder.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// What this block does
// R1: Primary I/O ignored while I/O enable clear
// R2: Secondary I/O and memory ignored without master enable
// R3: Primary claims inside window, secondary outside
// R4: Address unchanged, no decode gaps
// R5: Base above limit disables window
// R6: Window decoded on 4 kB granules
// R7: Base low byte: bits 15..12, nibble 1h
// R8: Base low twelve bits compare as zero
// R9: Base upper half register, resets zero
// R10: Limit low byte: bits 15..12, nibble 1h
// R11: Limit low twelve bits compare as ones
// R12: Limit upper half register, resets zero (full limit 0000_0FFF)
// R13: ISA mode acts only in-window below 64 kB
// R14: ISA mode forwards only low 256 bytes
// R15: Above 64 kB window alone decides
// R16: ISA upper 768 bytes forwarded upstream
// R17: Otherwise upstream only outside window
// R18: Software programs window before enabling forwarding
// R19: Master enable also gates upstream memory
// R20: Window test inclusive at both ends
module pci_bridge_io_address_decoder
  import io_decode_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire txn_type     pri_txn,
  input  wire txn_type     sec_txn,
  input  wire logic        sec_mem_upstream,
  output fwd_type          down_fwd,
  output fwd_type          up_fwd,
  output logic             window_on
);

  logic [3:0]  base_nib_reg;
  logic [3:0]  limit_nib_reg;
  logic [15:0] base_hi_reg;
  logic [15:0] limit_hi_reg;
  logic        io_en_reg;
  logic        mst_en_reg;
  logic        isa_en_reg;
  logic [31:0] full_base;
  logic [31:0] full_limit;
  logic        pri_claim;
  logic        sec_claim;

  function automatic logic in_window(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] l);
    in_window = (a >= b) && (a <= l); // R20
  endfunction

  function automatic logic isa_alias(input logic [31:0] a);
    isa_alias = (a[31:16] == ISA_TOP_ZERO) && (a[9:8] != ISA_LOW_CHUNK); // R13 R14
  endfunction

  // Window registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_nib_reg  <= BASE_NIB_RST; // R9
      limit_nib_reg <= LIMIT_NIB_RST; // R12
      base_hi_reg   <= BASE_HI_RST; // R9
      limit_hi_reg  <= LIMIT_HI_RST; // R12
    end else if (reg_write) begin
      unique case (reg_addr)
        OFF_BASE_LOW:   base_nib_reg  <= reg_wdata[7:4]; // R7
        OFF_LIMIT_LOW:  limit_nib_reg <= reg_wdata[7:4]; // R10
        OFF_BASE_HIGH:  base_hi_reg   <= reg_wdata[15:0]; // R9
        OFF_LIMIT_HIGH: limit_hi_reg  <= reg_wdata[15:0]; // R12
        default: ;
      endcase
    end
  end

  // Control bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_en_reg  <= 1'b0;
      mst_en_reg <= 1'b0;
      isa_en_reg <= 1'b0;
    end else if (reg_write && reg_addr == OFF_CONTROL) begin
      io_en_reg  <= reg_wdata[CTL_IO_EN];
      mst_en_reg <= reg_wdata[CTL_MST_EN];
      isa_en_reg <= reg_wdata[CTL_ISA_EN];
    end
  end

  // Read path
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        OFF_BASE_LOW:   reg_rdata <= {24'h00_0000, base_nib_reg, IO_CAP_32}; // R7
        OFF_LIMIT_LOW:  reg_rdata <= {24'h00_0000, limit_nib_reg, IO_CAP_32}; // R10
        OFF_BASE_HIGH:  reg_rdata <= {16'h0000, base_hi_reg};
        OFF_LIMIT_HIGH: reg_rdata <= {16'h0000, limit_hi_reg};
        OFF_CONTROL:    reg_rdata <= {28'h000_0000, window_on, isa_en_reg,
                                      mst_en_reg, io_en_reg};
        default:        reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  assign full_base  = {base_hi_reg, base_nib_reg, BASE_LOW_FILL}; // R6 R8
  assign full_limit = {limit_hi_reg, limit_nib_reg, LIMIT_LOW_FILL}; // R6 R11
  assign window_on  = full_base <= full_limit; // R5

  // Claim decisions
  always_comb begin
    pri_claim = 1'b0;
    sec_claim = 1'b0;
    if (pri_txn.valid && pri_txn.kind == CMD_IO && io_en_reg) begin // R1
      pri_claim = window_on && in_window(pri_txn.addr, full_base, full_limit) // R3 R5
                  && !(isa_en_reg && isa_alias(pri_txn.addr)); // R14 R15
    end
    if (sec_txn.valid && mst_en_reg) begin // R2
      if (sec_txn.kind == CMD_IO) begin
        sec_claim = !(window_on && in_window(sec_txn.addr, full_base, full_limit)) // R4 R17
                    || (isa_en_reg && isa_alias(sec_txn.addr)); // R16
      end else if (sec_txn.kind == CMD_MEM) begin
        sec_claim = sec_mem_upstream; // R19
      end
    end
  end

  // Registered forwarding outputs, address passed untranslated
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      down_fwd <= '0;
    end else begin
      down_fwd.claim <= pri_claim;
      down_fwd.addr  <= pri_txn.addr; // R4
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_fwd <= '0;
    end else begin
      up_fwd.claim <= sec_claim;
      up_fwd.addr  <= sec_txn.addr; // R4
    end
  end

  a_pri_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    !$past(io_en_reg) |-> !down_fwd.claim)
    else $error("downstream claim with I/O enable clear");

  a_sec_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    !$past(mst_en_reg) |-> !up_fwd.claim)
    else $error("upstream claim with master enable clear");

  a_no_overlap: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    $past(pri_txn.valid && sec_txn.valid && pri_txn.addr == sec_txn.addr
          && pri_txn.kind == CMD_IO && sec_txn.kind == CMD_IO && !isa_en_reg)
    |-> !(down_fwd.claim && up_fwd.claim))
    else $error("same address claimed both ways");

  a_addr_kept: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
    down_fwd.claim |-> down_fwd.addr == $past(pri_txn.addr))
    else $error("downstream address altered");

  a_off_window: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    $past(!window_on) |-> !down_fwd.claim)
    else $error("downstream claim with window off");

  a_low_nibble: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    $past(reg_read && reg_addr == OFF_BASE_LOW) |-> reg_rdata[3:0] == IO_CAP_32)
    else $error("base low nibble not 1h");

  a_isa_block: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    $past(isa_en_reg && pri_txn.addr[31:16] == ISA_TOP_ZERO
          && pri_txn.addr[9:8] != ISA_LOW_CHUNK) |-> !down_fwd.claim)
    else $error("ISA alias forwarded downstream");

  a_isa_up: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
    $past(sec_txn.valid && sec_txn.kind == CMD_IO && mst_en_reg && isa_en_reg
          && sec_txn.addr[31:16] == ISA_TOP_ZERO && sec_txn.addr[9:8] != ISA_LOW_CHUNK)
    |-> up_fwd.claim)
    else $error("ISA alias not forwarded upstream");

  // Field positions used by the checks below
  localparam int unsigned GRAN_LSB      = 12;
  localparam int unsigned PAGE_W        = ADDR_W - GRAN_LSB;
  localparam int unsigned ISA_TOP_LSB   = 16;
  localparam int unsigned ISA_CHUNK_MSB = 9;
  localparam int unsigned ISA_CHUNK_LSB = 8;
  localparam int unsigned HALF_W        = 16;
  localparam int unsigned NIB_MSB       = 7;
  localparam int unsigned NIB_LSB       = 4;
  localparam int unsigned CTL_WIN_ON    = 3;

  logic [PAGE_W-1:0] base_page;
  logic [PAGE_W-1:0] limit_page;

  // Window bounds in 4 kB pages, independent of the fill constants
  assign base_page  = {base_hi_reg, base_nib_reg};
  assign limit_page = {limit_hi_reg, limit_nib_reg};

  function automatic logic page_in(input logic [ADDR_W-1:0] a,
                                   input logic [PAGE_W-1:0] b,
                                   input logic [PAGE_W-1:0] l);
    page_in = (a[ADDR_W-1:GRAN_LSB] >= b) && (a[ADDR_W-1:GRAN_LSB] <= l);
  endfunction

  function automatic logic below_64k(input logic [ADDR_W-1:0] a);
    below_64k = a[ADDR_W-1:ISA_TOP_LSB] == ISA_TOP_ZERO;
  endfunction

  function automatic logic low_chunk(input logic [ADDR_W-1:0] a);
    low_chunk = a[ISA_CHUNK_MSB:ISA_CHUNK_LSB] == ISA_LOW_CHUNK;
  endfunction

  // Enabled I/O request on each bus, and enabled memory request on secondary
  sequence s_pri_io;
    pri_txn.valid && pri_txn.kind == CMD_IO && io_en_reg;
  endsequence

  sequence s_sec_io;
    sec_txn.valid && sec_txn.kind == CMD_IO && mst_en_reg;
  endsequence

  sequence s_sec_mem;
    sec_txn.valid && sec_txn.kind == CMD_MEM && mst_en_reg;
  endsequence

  a_pri_hit: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    s_pri_io ##0 (!isa_en_reg && page_in(pri_txn.addr, base_page, limit_page))
    |=> down_fwd.claim)
    else $error("in-window primary I/O not claimed");

  a_pri_miss: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    s_pri_io ##0 !page_in(pri_txn.addr, base_page, limit_page)
    |=> !down_fwd.claim)
    else $error("out-of-window primary I/O claimed");

  a_pri_not_io: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    !(pri_txn.valid && pri_txn.kind == CMD_IO)
    |=> !down_fwd.claim)
    else $error("non-I/O primary request claimed");

  a_isa_low_down: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    s_pri_io ##0 (isa_en_reg && page_in(pri_txn.addr, base_page, limit_page)
                  && below_64k(pri_txn.addr) && low_chunk(pri_txn.addr))
    |=> down_fwd.claim)
    else $error("ISA low chunk not forwarded downstream");

  a_pri_above: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
    s_pri_io ##0 (page_in(pri_txn.addr, base_page, limit_page)
                  && !below_64k(pri_txn.addr))
    |=> down_fwd.claim)
    else $error("in-window address above 64 kB not claimed");

  a_isa_outside: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
    s_pri_io ##0 (isa_en_reg && below_64k(pri_txn.addr) && low_chunk(pri_txn.addr)
                  && !page_in(pri_txn.addr, base_page, limit_page))
    |=> !down_fwd.claim)
    else $error("ISA mode claimed outside window");

  a_sec_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3 R17
    s_sec_io ##0 !page_in(sec_txn.addr, base_page, limit_page)
    |=> up_fwd.claim)
    else $error("out-of-window secondary I/O not forwarded");

  a_sec_in: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
    s_sec_io ##0 (!isa_en_reg && page_in(sec_txn.addr, base_page, limit_page))
    |=> !up_fwd.claim)
    else $error("in-window secondary I/O forwarded");

  a_sec_isa_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16 R17
    s_sec_io ##0 (isa_en_reg && page_in(sec_txn.addr, base_page, limit_page)
                  && below_64k(sec_txn.addr) && low_chunk(sec_txn.addr))
    |=> !up_fwd.claim)
    else $error("ISA low chunk forwarded upstream");

  a_sec_isa_hi: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
    s_sec_io ##0 (isa_en_reg && page_in(sec_txn.addr, base_page, limit_page)
                  && below_64k(sec_txn.addr) && !low_chunk(sec_txn.addr))
    |=> up_fwd.claim)
    else $error("in-window ISA alias not forwarded upstream");

  a_sec_above: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13 R15
    s_sec_io ##0 (isa_en_reg && page_in(sec_txn.addr, base_page, limit_page)
                  && !below_64k(sec_txn.addr))
    |=> !up_fwd.claim)
    else $error("in-window address above 64 kB forwarded upstream");

  a_win_off_up: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    s_sec_io ##0 !window_on
    |=> up_fwd.claim)
    else $error("secondary I/O held back with window off");

  a_mem_up: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
    s_sec_mem ##0 sec_mem_upstream
    |=> up_fwd.claim)
    else $error("secondary memory not forwarded upstream");

  a_mem_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
    s_sec_mem ##0 !sec_mem_upstream
    |=> !up_fwd.claim)
    else $error("secondary memory forwarded without decode");

  a_sec_other: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sec_txn.valid && sec_txn.kind == CMD_OTHER
    |=> !up_fwd.claim)
    else $error("other command forwarded upstream");

  a_up_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
    up_fwd.claim |-> up_fwd.addr == $past(sec_txn.addr))
    else $error("upstream address altered");

  a_window_flag: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5 R20
    window_on == (base_page <= limit_page))
    else $error("window flag disagrees with bounds");

  a_fill_bits: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8 R11
    full_base[GRAN_LSB-1:0] == BASE_LOW_FILL && full_limit[GRAN_LSB-1:0] == LIMIT_LOW_FILL)
    else $error("window low bits not filled");

  a_limit_nibble: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    $past(reg_read && reg_addr == OFF_LIMIT_LOW) |-> reg_rdata[3:0] == IO_CAP_32)
    else $error("limit low nibble not 1h");

  a_base_nib_rd: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    $past(reg_read && reg_addr == OFF_BASE_LOW)
    |-> reg_rdata[NIB_MSB:NIB_LSB] == $past(base_nib_reg))
    else $error("base low byte read wrong");

  a_limit_nib_rd: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    $past(reg_read && reg_addr == OFF_LIMIT_LOW)
    |-> reg_rdata[NIB_MSB:NIB_LSB] == $past(limit_nib_reg))
    else $error("limit low byte read wrong");

  a_base_nib_wr: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    $past(reg_write && reg_addr == OFF_BASE_LOW)
    |-> base_nib_reg == $past(reg_wdata[NIB_MSB:NIB_LSB]))
    else $error("base low byte write lost");

  a_limit_nib_wr: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    $past(reg_write && reg_addr == OFF_LIMIT_LOW)
    |-> limit_nib_reg == $past(reg_wdata[NIB_MSB:NIB_LSB]))
    else $error("limit low byte write lost");

  a_base_hi_wr: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    $past(reg_write && reg_addr == OFF_BASE_HIGH)
    |-> base_hi_reg == $past(reg_wdata[HALF_W-1:0]))
    else $error("base upper half write lost");

  a_limit_hi_wr: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
    $past(reg_write && reg_addr == OFF_LIMIT_HIGH)
    |-> limit_hi_reg == $past(reg_wdata[HALF_W-1:0]))
    else $error("limit upper half write lost");

  a_base_hi_rd: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    $past(reg_read && reg_addr == OFF_BASE_HIGH)
    |-> reg_rdata == {16'h0000, $past(base_hi_reg)})
    else $error("base upper half read wrong");

  a_limit_hi_rd: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
    $past(reg_read && reg_addr == OFF_LIMIT_HIGH)
    |-> reg_rdata == {16'h0000, $past(limit_hi_reg)})
    else $error("limit upper half read wrong");

  a_ctl_wr: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1 R2
    $past(reg_write && reg_addr == OFF_CONTROL)
    |-> io_en_reg == $past(reg_wdata[CTL_IO_EN]) && mst_en_reg == $past(reg_wdata[CTL_MST_EN]))
    else $error("control write lost");

  a_ctl_rd: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    $past(reg_read && reg_addr == OFF_CONTROL)
    |-> reg_rdata[CTL_WIN_ON] == $past(window_on) && reg_rdata[CTL_ISA_EN] == $past(isa_en_reg))
    else $error("control read wrong");

  a_rd_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");

  a_unmapped_rd: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(reg_read && reg_addr != OFF_BASE_LOW && reg_addr != OFF_LIMIT_LOW
          && reg_addr != OFF_BASE_HIGH && reg_addr != OFF_LIMIT_HIGH
          && reg_addr != OFF_CONTROL)
    |-> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule // pci_bridge_io_address_decoder

/* File: core/io_decode_pkg.sv */
package io_decode_pkg;

  localparam int unsigned ADDR_W = 32;

  // Register byte addresses
  localparam logic [7:0] OFF_BASE_LOW   = 8'h1c;
  localparam logic [7:0] OFF_LIMIT_LOW  = 8'h1d;
  localparam logic [7:0] OFF_BASE_HIGH  = 8'h30;
  localparam logic [7:0] OFF_LIMIT_HIGH = 8'h32;
  localparam logic [7:0] OFF_CONTROL    = 8'h40;

  // Low nibble code for 32-bit I/O decoding
  localparam logic [3:0]  IO_CAP_32      = 4'h1;
  localparam logic [3:0]  BASE_NIB_RST   = 4'h0;
  localparam logic [3:0]  LIMIT_NIB_RST  = 4'h0;
  localparam logic [15:0] BASE_HI_RST    = 16'h0000;
  localparam logic [15:0] LIMIT_HI_RST   = 16'h0000;
  localparam logic [11:0] BASE_LOW_FILL  = 12'h000;
  localparam logic [11:0] LIMIT_LOW_FILL = 12'hfff;
  localparam logic [15:0] ISA_TOP_ZERO   = 16'h0000;
  localparam logic [1:0]  ISA_LOW_CHUNK  = 2'h0;

  // Control register bit positions
  localparam int unsigned CTL_IO_EN  = 0;
  localparam int unsigned CTL_MST_EN = 1;
  localparam int unsigned CTL_ISA_EN = 2;

  typedef enum logic [1:0] {
    CMD_IO,
    CMD_MEM,
    CMD_OTHER
  } cmd_kind_type;

  typedef struct packed {
    logic                valid;
    cmd_kind_type        kind;
    logic [ADDR_W-1:0]   addr;
  } txn_type;

  typedef struct packed {
    logic                claim;
    logic [ADDR_W-1:0]   addr;
  } fwd_type;

endpackage

/* File: verif/pci_initiators.sv */
`timescale 1ns/1ps
module pci_initiators
  import io_decode_pkg::*;
(
  input  wire logic ref_clk,
  output txn_type   pri_txn,
  output txn_type   sec_txn
);
  initial begin
    pri_txn = '0;
    sec_txn = '0;
  end
  // One request on each bus, launched just after a rising edge
  task automatic issue(input txn_type p, input txn_type s);
    @(posedge ref_clk);
    pri_txn <= p;
    sec_txn <= s;
  endtask
endmodule // pci_initiators

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb
  import io_decode_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic        sec_mem_upstream = 1'b0;
  txn_type     pri_txn;
  txn_type     sec_txn;
  fwd_type     down_fwd;
  fwd_type     up_fwd;
  logic        window_on;
  logic [31:0] b_full, l_full, d0, d1, d2, d3, pa, sa;
  logic [2:0]  ctl;
  txn_type     pt, st;
  int          n_mismatch = 0;
  int          checks_done = 0;
  always #20 ref_clk = ~ref_clk;
  pci_initiators i_ini (.ref_clk(ref_clk), .pri_txn(pri_txn), .sec_txn(sec_txn));
  pci_bridge_io_address_decoder i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pri_txn(pri_txn), .sec_txn(sec_txn), .sec_mem_upstream(sec_mem_upstream),
    .down_fwd(down_fwd), .up_fwd(up_fwd), .window_on(window_on));
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata === e, "read data");
  endtask
  function automatic logic in_win(input logic [31:0] a);
    return a >= b_full && a <= l_full;
  endfunction
  function automatic logic alias_hit(input logic [31:0] a);
    return ctl[2] && a[31:16] == 16'h0000 && a[9:8] != 2'h0;
  endfunction
  function automatic logic [31:0] pick();
    case ($urandom % 6)
      0: return b_full;
      1: return l_full;
      2: return b_full - 1;
      3: return l_full + 1;
      4: return {16'h0000, 16'($urandom)};
      default: return $urandom;
    endcase
  endfunction
  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(32'hb4b3_dbce));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(window_on === 1'b1, "reset window");
    rd(OFF_BASE_LOW, 32'h0000_0001);
    rd(OFF_LIMIT_LOW, 32'h0000_0001);
    rd(OFF_BASE_HIGH, 32'h0000_0000);
    rd(OFF_LIMIT_HIGH, 32'h0000_0000);
    rd(OFF_CONTROL, 32'h0000_0008);
    for (int i = 0; i < 300; i++) begin
      i_ini.issue('0, '0);
      wr(OFF_CONTROL, 32'h0000_0000);
      {d0, d1, d2, d3, ctl} = {$urandom, $urandom, $urandom, $urandom, 3'($urandom)};
      if (i % 2 == 0) d2[15:0] = 16'h0000;
      if (i % 3 == 0) d3[15:0] = d2[15:0];
      wr(OFF_BASE_LOW, d0);
      wr(OFF_LIMIT_LOW, d1);
      wr(OFF_BASE_HIGH, d2);
      wr(OFF_LIMIT_HIGH, d3);
      wr(8'h44, $urandom);
      b_full = {d2[15:0], d0[7:4], 12'h000};
      l_full = {d3[15:0], d1[7:4], 12'hfff};
      wr(OFF_CONTROL, {29'h0, ctl});
      rd(OFF_BASE_LOW, {24'h0, d0[7:4], 4'h1});
      rd(OFF_LIMIT_LOW, {24'h0, d1[7:4], 4'h1});
      rd(OFF_BASE_HIGH, {16'h0, d2[15:0]});
      rd(OFF_LIMIT_HIGH, {16'h0, d3[15:0]});
      rd(8'h44, 32'h0000_0000);
      rd(OFF_CONTROL, {28'h000_0000, b_full <= l_full, ctl});
      chk(window_on === (b_full <= l_full), "window on");
      repeat (8) begin
        pa = pick();
        sa = pick();
        pt = '{1'($urandom), cmd_kind_type'($urandom % 3), pa};
        st = '{1'($urandom), cmd_kind_type'($urandom % 3), sa};
        @(posedge ref_clk);
        sec_mem_upstream <= 1'($urandom);
        i_ini.issue(pt, st);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(down_fwd.claim === (ctl[0] && pt.valid && pt.kind == CMD_IO && in_win(pa)
          && !alias_hit(pa)), "down claim");
        if (down_fwd.claim === 1'b1) chk(down_fwd.addr === pa, "down addr");
        chk(up_fwd.claim === (ctl[1] && st.valid && (st.kind == CMD_IO ? (!in_win(sa)
          || alias_hit(sa)) : st.kind == CMD_MEM && sec_mem_upstream)), "up claim");
        if (up_fwd.claim === 1'b1) chk(up_fwd.addr === sa, "up addr");
      end
    end
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFF_BASE_LOW, 32'h0000_0001);
    rd(OFF_LIMIT_LOW, 32'h0000_0001);
    rd(OFF_BASE_HIGH, 32'h0000_0000);
    rd(OFF_LIMIT_HIGH, 32'h0000_0000);
    rd(OFF_CONTROL, 32'h0000_0008);
    close_out();
  end
endmodule // tb
